// ---- src/fbc_pkg.sv ----
package fbc_pkg;
   // register word indices; printed offsets are not all multiples of four,
   // so each printed offset is an index and the byte address is four times it
   localparam logic [3:0] IDX_FREQ_HIGH = 4'h8;
   localparam logic [3:0] IDX_FREQ_MID = 4'h9;
   localparam logic [3:0] IDX_FREQ_LOW = 4'hA;
   localparam logic [3:0] IDX_CLK_DIV = 4'hB;
   localparam logic [3:0] IDX_OSC_CUR = 4'hC;
   localparam logic [3:0] IDX_DIV_STATUS = 4'hD;
   // field positions
   localparam int FREQ_LOW_LSB = 1;
   localparam int DITHER_BIT = 0;
   localparam int REF_DIV_LSB = 5;
   localparam int PRESCALE_LSB = 2;
   localparam int POSTSCALE_LSB = 0;
   localparam int CUR_A_LSB = 4;
   localparam int CUR_B_LSB = 0;
   // reset values
   localparam logic [7:0] RST_FREQ_HIGH = 8'h83;
   localparam logic [7:0] RST_FREQ_MID = 8'hBD;
   localparam logic [6:0] RST_FREQ_LOW = 7'h7C;
   localparam logic RST_DITHER = 1'b1;
   localparam logic [2:0] RST_REF_DIV = 3'h2;
   localparam logic [2:0] RST_PRESCALE = 3'h4;
   localparam logic [1:0] RST_POSTSCALE = 2'h0;
   localparam logic [3:0] RST_CUR_A = 4'h8;
   localparam logic [3:0] RST_CUR_B = 4'h8;
   // 2 x 12.5 x 1 x 8 reference cycles per symbol, times two
   localparam logic [13:0] RST_SYM_DIV = 14'h00C8;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/fbc_regs.sv ----
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - high byte of word B (bits 22:15) at 0x08, resets to 131.
// - middle byte of word B (bits 14:7) at 0x09, resets to 189.
// - seven low bits of word B at 0x0A bits 7:1, reset 124.
// - bit 0 of 0x0A enables dithering for B, resets to one.
// - reference divisor bits 7:5 of 0x0B; code1 /2, code7 /8; reset 2.
// - prescale bits 4:2 of 0x0B: 2.5,3,4,7.5,12.5,40,48,64; reset 4.
// - postscale bits 1:0 of 0x0B divide by 1,2,4,8; reset 0.
// - modem clock is reference divided by prescale times postscale.
// - symbol rate is one eighth of the modem clock.
// - bits 7:4 of 0x0C oscillator current A, sixteen steps, reset 8.
// - bits 3:0 of 0x0C oscillator current B, same steps, reset 8.
module fbc_regs (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration outputs for setting b
   output logic [22:0] freq_word_b,
   output logic dither_en_b,
   output logic [2:0] ref_div_code_b,
   output logic [2:0] modem_prescale_b,
   output logic [1:0] modem_postscale_b,
   output logic [3:0] osc_core_current_a,
   output logic [3:0] osc_core_current_b,
   // total reference-to-symbol divide, in half steps (x2)
   output logic [13:0] symbol_div_x2_b
);

   ////////////////////////////////////////////////////////////////////////
   // decode and arithmetic helpers

   // word index from a byte address; upper bits must be zero
   function automatic logic [4:0] word_index(input logic [31:0] a);
      word_index = (a[31:6] == 26'h0) ? {1'b0, a[5:2]} : 5'h1F;
   endfunction

   // prescale ratio times two, so 2.5 and 7.5 stay integral
   function automatic logic [7:0] prescale_x2(input logic [2:0] c);
      case (c)
         3'h0: prescale_x2 = 8'h05;
         3'h1: prescale_x2 = 8'h06;
         3'h2: prescale_x2 = 8'h08;
         3'h3: prescale_x2 = 8'h0F;
         3'h4: prescale_x2 = 8'h19;
         3'h5: prescale_x2 = 8'h50;
         3'h6: prescale_x2 = 8'h60;
         default: prescale_x2 = 8'h80;
      endcase
   endfunction

   // merge a byte lane into an 8-bit register
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
      merge = st[0] ? wd[7:0] : old;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] freq_high_q, freq_high_d;
   logic [7:0] freq_mid_q, freq_mid_d;
   logic [6:0] freq_low_q, freq_low_d;
   logic dither_q, dither_d;
   logic [2:0] ref_div_q, ref_div_d;
   logic [2:0] prescale_q, prescale_d;
   logic [1:0] postscale_q, postscale_d;
   logic [3:0] cur_a_q, cur_a_d;
   logic [3:0] cur_b_q, cur_b_d;
   logic [13:0] sym_div_q, sym_div_d;

   // write channel state
   logic aw_held_q, aw_held_d, aw_rdy_q, aw_rdy_d;
   logic w_held_q, w_held_d, w_rdy_q, w_rdy_d;
   logic [31:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   // read channel state
   logic rvalid_q, rvalid_d, ar_rdy_q, ar_rdy_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   logic do_write;
   logic [4:0] widx;
   logic [4:0] ridx;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic rhit;

   ////////////////////////////////////////////////////////////////////////
   // write path: address and data are taken in either order

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && aw_rdy_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_q) begin
         w_held_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (widx >= {1'b0, fbc_pkg::IDX_FREQ_HIGH} &&
                    widx <= {1'b0, fbc_pkg::IDX_OSC_CUR}) ?
                   fbc_pkg::RESP_OKAY : fbc_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      aw_rdy_d = !aw_held_d && !bvalid_d;
      w_rdy_d = !w_held_d && !bvalid_d;
   end

   // one write in flight; response once both halves are held
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign widx = word_index(awaddr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 32'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         aw_rdy_q <= 1'b0;
         w_rdy_q <= 1'b0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         aw_rdy_q <= aw_rdy_d;
         w_rdy_q <= w_rdy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file next state; only byte lane 0 carries data

   always_comb begin
      freq_high_d = freq_high_q;
      freq_mid_d = freq_mid_q;
      freq_low_d = freq_low_q;
      dither_d = dither_q;
      ref_div_d = ref_div_q;
      prescale_d = prescale_q;
      postscale_d = postscale_q;
      cur_a_d = cur_a_q;
      cur_b_d = cur_b_q;
      wbyte = 8'h0;
      if (do_write) begin
         if (widx == {1'b0, fbc_pkg::IDX_FREQ_HIGH}) begin
            freq_high_d = merge(freq_high_q, wdata_q, wstrb_q);
         end else if (widx == {1'b0, fbc_pkg::IDX_FREQ_MID}) begin
            freq_mid_d = merge(freq_mid_q, wdata_q, wstrb_q);
         end else if (widx == {1'b0, fbc_pkg::IDX_FREQ_LOW}) begin
            wbyte = merge({freq_low_q, dither_q}, wdata_q, wstrb_q);
            freq_low_d = wbyte[7:fbc_pkg::FREQ_LOW_LSB];
            dither_d = wbyte[fbc_pkg::DITHER_BIT];
         end else if (widx == {1'b0, fbc_pkg::IDX_CLK_DIV}) begin
            wbyte = merge({ref_div_q, prescale_q, postscale_q},
                          wdata_q, wstrb_q);
            // code 0 is stored as written; the host must avoid it
            ref_div_d = wbyte[7:fbc_pkg::REF_DIV_LSB];
            prescale_d = wbyte[4:fbc_pkg::PRESCALE_LSB];
            postscale_d = wbyte[1:fbc_pkg::POSTSCALE_LSB];
         end else if (widx == {1'b0, fbc_pkg::IDX_OSC_CUR}) begin
            wbyte = merge({cur_a_q, cur_b_q}, wdata_q, wstrb_q);
            cur_a_d = wbyte[7:fbc_pkg::CUR_A_LSB];
            cur_b_d = wbyte[3:fbc_pkg::CUR_B_LSB];
         end
      end
      // total divide x2: prescale_x2 shifted by postscale, times 8 per symbol
      sym_div_d = 14'(({6'h0, prescale_x2(prescale_d)} << postscale_d)
                      << 3);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_high_q <= fbc_pkg::RST_FREQ_HIGH;
         freq_mid_q <= fbc_pkg::RST_FREQ_MID;
         freq_low_q <= fbc_pkg::RST_FREQ_LOW;
         dither_q <= fbc_pkg::RST_DITHER;
         ref_div_q <= fbc_pkg::RST_REF_DIV;
         prescale_q <= fbc_pkg::RST_PRESCALE;
         postscale_q <= fbc_pkg::RST_POSTSCALE;
         cur_a_q <= fbc_pkg::RST_CUR_A;
         cur_b_q <= fbc_pkg::RST_CUR_B;
         sym_div_q <= fbc_pkg::RST_SYM_DIV; // 2 x 12.5 x 1 x 8
      end else begin
         freq_high_q <= freq_high_d;
         freq_mid_q <= freq_mid_d;
         freq_low_q <= freq_low_d;
         dither_q <= dither_d;
         ref_div_q <= ref_div_d;
         prescale_q <= prescale_d;
         postscale_q <= postscale_d;
         cur_a_q <= cur_a_d;
         cur_b_q <= cur_b_d;
         sym_div_q <= sym_div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path; status word at 0x0D shows divide ratios

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      rbyte = 8'h0;
      rhit = 1'b1;
      if (ridx == {1'b0, fbc_pkg::IDX_FREQ_HIGH}) begin
         rbyte = freq_high_q;
      end else if (ridx == {1'b0, fbc_pkg::IDX_FREQ_MID}) begin
         rbyte = freq_mid_q;
      end else if (ridx == {1'b0, fbc_pkg::IDX_FREQ_LOW}) begin
         rbyte = {freq_low_q, dither_q};
      end else if (ridx == {1'b0, fbc_pkg::IDX_CLK_DIV}) begin
         rbyte = {ref_div_q, prescale_q, postscale_q};
      end else if (ridx == {1'b0, fbc_pkg::IDX_OSC_CUR}) begin
         rbyte = {cur_a_q, cur_b_q};
      end else if (ridx != {1'b0, fbc_pkg::IDX_DIV_STATUS}) begin
         rhit = 1'b0;
      end
      if (s_axi_arvalid && ar_rdy_q) begin
         rvalid_d = 1'b1;
         rresp_d = rhit ? fbc_pkg::RESP_OKAY : fbc_pkg::RESP_SLVERR;
         if (ridx == {1'b0, fbc_pkg::IDX_DIV_STATUS}) begin
            // reference divide is code+1 for codes 1..7
            rdata_d = {2'h0, sym_div_q, 12'h0, {1'b0, ref_div_q} + 4'h1};
         end else begin
            rdata_d = {24'h0, rbyte};
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      ar_rdy_d = !rvalid_d;
   end

   assign ridx = word_index(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= 2'h0;
         ar_rdy_q <= 1'b0;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         ar_rdy_q <= ar_rdy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops

   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready = w_rdy_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign freq_word_b = {freq_high_q, freq_mid_q, freq_low_q};
   assign dither_en_b = dither_q;
   assign ref_div_code_b = ref_div_q;
   assign modem_prescale_b = prescale_q;
   assign modem_postscale_b = postscale_q;
   assign osc_core_current_a = cur_a_q;
   assign osc_core_current_b = cur_b_q;
   assign symbol_div_x2_b = sym_div_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_clk_write;
      do_write && widx == {1'b0, fbc_pkg::IDX_CLK_DIV} && wstrb_q[0];
   endsequence

   a_high_reset: assert property (@(posedge aclk)
      $rose(aresetn) |-> freq_word_b[22:15] == 8'h83)
      else $error("high byte reset wrong");
   a_mid_reset: assert property (@(posedge aclk)
      $rose(aresetn) |-> freq_word_b[14:7] == 8'hBD)
      else $error("mid byte reset wrong");
   a_low_reset: assert property (@(posedge aclk)
      $rose(aresetn) |-> freq_word_b[6:0] == 7'h7C)
      else $error("low bits reset wrong");
   a_dither_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      do_write && widx == {1'b0, fbc_pkg::IDX_FREQ_LOW} && wstrb_q[0]
      |=> dither_en_b == $past(wdata_q[0]))
      else $error("dither bit not written");
   a_ref_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_clk_write |=> ref_div_code_b == $past(wdata_q[7:5]))
      else $error("reference divisor not written");
   a_pre_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_clk_write |=> modem_prescale_b == $past(wdata_q[4:2]))
      else $error("prescale not written");
   a_post_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_clk_write |=> modem_postscale_b == $past(wdata_q[1:0]))
      else $error("postscale not written");
   a_sym_div: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_clk_write ##1 1'b1 |=> symbol_div_x2_b ==
         14'((prescale_x2($past(modem_prescale_b)) <<
              $past(modem_postscale_b)) * 8))
      else $error("symbol divide wrong");
   a_cur_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      do_write && widx == {1'b0, fbc_pkg::IDX_OSC_CUR} && wstrb_q[0]
      |=> {osc_core_current_a, osc_core_current_b} == $past(wdata_q[7:0]))
      else $error("current field not written");
   a_bresp_hold: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule // fbc_regs

// ---- tb/fbc_host.sv ----
`timescale 1ns/1ps
// axi4-lite master standing in for the host controller
module fbc_host (
   // clock
   input wire logic aclk,
   // write channels
   output logic [31:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic [31:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   output logic rready
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   ////////////////////////////////////////////////////////////
   // one write; lag holds bready low a while to act as a slow host
   task automatic write(input logic [31:0] a, d, input logic [3:0] s,
                        input int lag);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      forever begin
         @(posedge aclk);
         if (bvalid && bready) break;
         n++;
         // released address and data lines show the inverse, never the stale value
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (n >= lag) bready <= 1'b1;
      end
      bready <= 1'b0;
   endtask
   // one read, same slow-host option
   task automatic read(input logic [31:0] a, input int lag);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
      forever begin
         @(posedge aclk);
         if (rvalid && rready) break;
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (n >= lag) rready <= 1'b1;
      end
      rready <= 1'b0;
   endtask
endmodule // fbc_host

// ---- tb/fbc_regs_tb.sv ----
`timescale 1ns/1ps
module fbc_regs_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb, cur_a, cur_b;
   logic awvalid, awready, wvalid, wready, bvalid, bready, dither;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, post;
   logic [22:0] fw;
   logic [2:0] rf_code, pre;
   logic [13:0] sym;
   logic [34:0] e;
   logic [34:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] seed = 32'h92306B1D;
   int n_errors = 0;
   int checks = 0;
   int px2[8] = '{5, 6, 8, 15, 25, 80, 96, 128};
   logic [7:0] rst[5] = '{8'h83, 8'hBD, 8'hF9, 8'h50, 8'h88};
   always #2 aclk = ~aclk;
   fbc_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
   fbc_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .freq_word_b(fw),
      .dither_en_b(dither), .ref_div_code_b(rf_code),
      .modem_prescale_b(pre), .modem_postscale_b(post),
      .osc_core_current_a(cur_a), .osc_core_current_b(cur_b),
      .symbol_div_x2_b(sym));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction
   task automatic cmp_bus(input logic [33:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [23:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t port got %h exp %h", $time, got, exp);
      end
   endtask
   // note the expected answer, then let the host issue the access
   task automatic rd(input logic [31:0] a, d, input logic [1:0] r,
                     input logic c);
      rq.push_back({c, r, d});
      host.read(a, int'(seed[1:0]));
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
                     input logic [1:0] r, input int lag);
      bq.push_back(r);
      host.write(a, d, s, lag);
   endtask
   // watcher pairs each answer with the oldest note; data masked on errors
   always @(posedge aclk) begin
      if (aresetn && rvalid && rready) begin
         e = rq.pop_front();
         cmp_bus({rresp, e[34] ? rdata : 32'h0},
                 {e[33:32], e[34] ? e[31:0] : 32'h0});
      end
      if (aresetn && bvalid && bready) cmp_bus({bresp, 32'h0},
                                               {bq.pop_front(), 32'h0});
   end
   ////////////////////////////////////////////////////////////
   task automatic chk_reset();
      rd(32'h20, rst[0], 2'h0, 1'b1);
      rd(32'h24, rst[1], 2'h0, 1'b1);
      rd(32'h28, rst[2], 2'h0, 1'b1);
      rd(32'h2C, rst[3], 2'h0, 1'b1);
      rd(32'h30, rst[4], 2'h0, 1'b1);
      rd(32'h34, 32'h00C80003, 2'h0, 1'b1);
      cmp_out({fw, dither}, {23'h41DEFC, 1'b1});
      cmp_out({rf_code, pre, post}, 8'h50);
      cmp_out({cur_a, cur_b}, 8'h88);
      cmp_out(sym, 14'h00C8);
      $display("test reset done");
   endtask
   task automatic t_random();
      logic [7:0] v[5];
      for (int n = 0; n < 8; n++) begin
         for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            v[k] = seed[7:0];
            if (k == 3 && v[3][7:5] == 3'h0) v[3][7:5] = 3'h1;
            wr(32'h20 + 4 * k, {seed[31:8], v[k]}, 4'hF, 2'h0,
               int'(seed[9:8]));
         end
         for (int k = 0; k < 5; k++)
            rd(32'h20 + 4 * k, v[k], 2'h0, 1'b1);
         cmp_out(fw, {v[0], v[1], v[2][7:1]});
         cmp_out(dither, v[2][0]);
         cmp_out({rf_code, pre, post}, v[3]);
         cmp_out({cur_a, cur_b}, v[4]);
      end
      $display("test random done");
   endtask
   // every prescale and postscale code, reference codes 1 to 7
   task automatic t_div();
      logic [2:0] rf;
      int sx2;
      logic [31:0] st;
      for (int i = 0; i < 32; i++) begin
         rf = 3'(i % 7 + 1);
         wr(32'h2C, {24'h0, rf, i[2:0], i[4:3]}, 4'h1, 2'h0, 0);
         sx2 = px2[i[2:0]] * (1 << i[4:3]) * 8;
         repeat (2) @(posedge aclk);
         cmp_out({rf_code, pre, post}, {rf, i[2:0], i[4:3]});
         cmp_out(sym, sx2);
         st = {2'h0, 14'(sx2), 12'h0, {1'b0, rf} + 4'h1};
         rd(32'h34, st, 2'h0, 1'b1);
      end
      $display("test dividers done");
   endtask
   task automatic t_err();
      wr(32'h38, 32'hFF, 4'hF, 2'h2, 0);
      rd(32'h38, 32'h0, 2'h2, 1'b0);
      wr(32'h34, 32'h0, 4'hF, 2'h2, 1);
      wr(32'h20, 32'h11, 4'hE, 2'h0, 2);
      rd(32'h20, 32'h83, 2'h0, 1'b1);
      wr(32'h30, 32'h44, 4'h1, 2'h0, 0);
      cmp_out({cur_a, cur_b}, 8'h44);
      $display("test errors done");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence, with a second reset in mid-run
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      chk_reset();
      t_random();
      t_div();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      chk_reset();
      t_err();
      end_of_test();
   end
   // watchdog at 50000 cycles, far beyond the thousand or so cycles the tests need
   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end
endmodule // fbc_regs_tb
